// ==== rcsm_map.svh ====
// Register offsets, field positions, reset values and timing counts of the regulator control block
`ifndef RCSM_MAP_SVH
`define RCSM_MAP_SVH
`define RCSM_I2C_ADDR_HI      4'h1
`define RCSM_OFS_VOUT_HI      8'h0a
`define RCSM_OFS_VOUT_LO      8'h0b
`define RCSM_OFS_ILIM         8'h0c
`define RCSM_OFS_MINI_CFG     8'h0f
`define RCSM_OFS_STATUS       8'h00
`define RCSM_MINI_CFG_RST     8'h9e
`define RCSM_VOUT_HI_RST      8'h00
`define RCSM_VOUT_LO_RST      8'h00
`define RCSM_ILIM_RST         8'hff
`define RCSM_BIT_FULL_DUTY    7
`define RCSM_BIT_SPREAD       6
`define RCSM_BIT_FCCM         5
`define RCSM_HSD_MSB          4
`define RCSM_HSD_LSB          3
`define RCSM_LSD_MSB          2
`define RCSM_LSD_LSB          1
`define RCSM_PTR_INC_BIT      4'h5
`define RCSM_BIAS_RESET_US    100
`define RCSM_CLK_MHZ          40
`define RCSM_BIAS_RESET_CYC   (`RCSM_BIAS_RESET_US * `RCSM_CLK_MHZ)
`endif

// ==== rcsm_pkg.sv ====
// Types shared by the regulator control block
package rcsm_pkg;
  typedef enum logic [3:0] {
    ST_NO_POWER, ST_BIAS_RAMP, ST_FREQ_CHECK, ST_BIAS_READY, ST_MAIN_RAMP,
    ST_MAIN_ON, ST_SERVO, ST_BIAS_RESET, ST_MAIN_SHUTDOWN, ST_MAIN_ERROR
  } rcsm_state_e;
  typedef enum logic [2:0] {
    I2C_IDLE, I2C_ADDR, I2C_REGADDR, I2C_WDATA, I2C_RDATA, I2C_IGNORE
  } rcsm_i2c_e;
  // Raw condition flags from analog monitors
  typedef struct packed {
    logic power_ok;
    logic mini_up;
    logic freq_valid;
    logic bias_fault;
    logic output_good;
    logic servo_done;
    logic shutdown_fault;
    logic shutdown_done;
    logic hiccup_fault;
    logic hiccup_timeout;
  } rcsm_mon_s;
  // Mini-converter configuration outputs
  typedef struct packed {
    logic       full_duty;
    logic       spread;
    logic       fccm;
    logic [1:0] high_side_drive_strength;
    logic [1:0] low_side_drive_strength;
  } rcsm_mini_cfg_s;
  // Clock role picked by the address strap
  typedef struct packed {
    logic sync_enable;
    logic sync_is_output;
    logic sync_falling;
  } rcsm_clk_role_s;
endpackage

// ==== rcsm_control.sv ====
// Regulator control state machine with I2C target and mini-converter configuration
//
// Contract
// - Power loss or UV/OV forces unpowered state
// - Bias ramp, frequency check, then bias ready
// - Bias ready holds bias_good; enable rise ramps
// - Ramp keeps bias_good; output_good rise turns on
// - On drives both goods; target writes enter servo
// - Servo drops output_good; completion returns to on
// - Bias faults enter bias reset, delay returns
// - Enable high faults enter shutdown, then ready
// - Hiccup faults enter error; timeout or disable exits
// - I2C target answers only with bias_good high
// - Host reads status, writes and reads settings
// - Strap picks one of six I2C addresses
// - Strap also picks clock role
// - Config bit 7 full duty, reset one
// - Config bit 6 spread spectrum, reset zero
// - Config bit 5 forced continuous conduction
// - High-side drive field bits 4:3, reset 11
// - Low-side drive field bits 2:1, reset 11
// - Pointer loads at register address ack, increments per write
// - Read increments pointer at fifth clock
`timescale 1ns/1ps
`include "rcsm_map.svh"
module rcsm_control #(
  parameter int unsigned BIAS_RESET_CYC = `RCSM_BIAS_RESET_CYC
) (
  input  wire logic                    i_core_clk,
  input  wire logic                    i_rst_n,
  input  wire rcsm_pkg::rcsm_mon_s     i_mon,
  input  wire logic                    i_enable,
  input  wire logic                    i_internal_enable_gated,
  input  wire logic [2:0]              i_address_strap_resistor,
  input  wire logic                    i_scl,
  input  wire logic                    i_sda,
  output logic                         o_sda_oe_n,
  output logic                         o_bias_good,
  output logic                         o_output_good,
  output logic                         o_main_enable,
  output rcsm_pkg::rcsm_state_e        o_state,
  output rcsm_pkg::rcsm_mini_cfg_s     o_mini_cfg,
  output rcsm_pkg::rcsm_clk_role_s     o_clk_role
);
  import rcsm_pkg::*;

  // Two-stage synchronisers for the monitors, enables and strap; the bus lines get three stages below
  rcsm_mon_s  mon_s1_reg, mon_reg;
  logic [1:0] en_s1_reg, en_reg;
  logic [2:0] scl_s1_reg, sda_s1_reg;
  logic [1:0] scl_hist_reg, sda_hist_reg;
  logic [2:0] strap_s1_reg, strap_reg;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mon_s1_reg   <= '0;
      mon_reg      <= '0;
      en_s1_reg    <= 2'h0;
      en_reg       <= 2'h0;
      strap_s1_reg <= 3'h0;
      strap_reg    <= 3'h0;
    end else begin
      mon_s1_reg   <= i_mon;
      mon_reg      <= mon_s1_reg;
      en_s1_reg    <= {i_internal_enable_gated, i_enable};
      en_reg       <= en_s1_reg;
      strap_s1_reg <= i_address_strap_resistor;
      strap_reg    <= strap_s1_reg;
    end
  end

  // Bus lines: three-stage synchroniser plus one history stage for edge detection
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_s1_reg   <= 3'h7;
      sda_s1_reg   <= 3'h7;
      scl_hist_reg <= 2'h3;
      sda_hist_reg <= 2'h3;
    end else begin
      scl_s1_reg   <= {scl_s1_reg[1:0], i_scl};
      sda_s1_reg   <= {sda_s1_reg[1:0], i_sda};
      scl_hist_reg <= scl_s1_reg[2:1];
      sda_hist_reg <= sda_s1_reg[2:1];
    end
  end

  logic enable_now, enable_prev, ien_now, ien_prev;
  assign enable_now  = en_reg[0];
  assign ien_now     = en_reg[1];
  logic enable_d_reg, ien_d_reg;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      enable_d_reg <= 1'b0;
      ien_d_reg    <= 1'b0;
    end else begin
      enable_d_reg <= enable_now;
      ien_d_reg    <= ien_now;
    end
  end
  assign enable_prev = enable_d_reg;
  assign ien_prev    = ien_d_reg;

  logic scl_now, sda_now, scl_rise, scl_fall, start_seen, stop_seen;
  assign scl_now    = scl_hist_reg[0];
  assign sda_now    = sda_hist_reg[0];
  assign scl_rise   = scl_hist_reg[0] && !scl_hist_reg[1];
  assign scl_fall   = !scl_hist_reg[0] && scl_hist_reg[1];
  assign start_seen = scl_now && scl_hist_reg[1] && !sda_hist_reg[0] && sda_hist_reg[1];
  assign stop_seen  = scl_now && scl_hist_reg[1] && sda_hist_reg[0] && !sda_hist_reg[1];

  // Register file
  logic [7:0] vout_hi_reg, vout_lo_reg, ilim_reg, mini_cfg_reg;
  logic       target_change;
  rcsm_state_e state_reg, state_next;

  function automatic logic [7:0] read_mux(input logic [7:0] ofs, input logic [7:0] st);
    unique case (ofs)
      `RCSM_OFS_STATUS:   read_mux = st;
      `RCSM_OFS_VOUT_HI:  read_mux = vout_hi_reg;
      `RCSM_OFS_VOUT_LO:  read_mux = vout_lo_reg;
      `RCSM_OFS_ILIM:     read_mux = ilim_reg;
      `RCSM_OFS_MINI_CFG: read_mux = {mini_cfg_reg[7:1], 1'b0};
      default:            read_mux = 8'h00;
    endcase
  endfunction

  // Bias reset delay counter
  logic [$clog2(BIAS_RESET_CYC+1)-1:0] delay_cnt_reg;
  logic delay_done;
  assign delay_done = (delay_cnt_reg == '0);
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      delay_cnt_reg <= '0;
    end else if (state_reg != ST_BIAS_RESET) begin
      delay_cnt_reg <= ($clog2(BIAS_RESET_CYC+1))'(BIAS_RESET_CYC - 1);
    end else if (!delay_done) begin
      delay_cnt_reg <= delay_cnt_reg - 1'b1;
    end
  end

  // Control state machine; power events win over all, then bias, then main faults
  logic output_good_prev_reg;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      output_good_prev_reg <= 1'b0;
    end else begin
      output_good_prev_reg <= mon_reg.output_good;
    end
  end

  always_comb begin
    logic normal;
    normal     = (state_reg inside {ST_BIAS_RAMP, ST_BIAS_READY, ST_MAIN_RAMP, ST_MAIN_ON, ST_SERVO});
    state_next = state_reg;
    if (!mon_reg.power_ok) begin
      state_next = ST_NO_POWER;
    end else if (normal && mon_reg.bias_fault) begin
      state_next = ST_BIAS_RESET;
    end else if (enable_now && (state_reg inside {ST_MAIN_RAMP, ST_MAIN_ON, ST_SERVO, ST_MAIN_ERROR})
                 && ((ien_prev && !ien_now) || mon_reg.shutdown_fault) && state_reg != ST_MAIN_ERROR) begin
      state_next = ST_MAIN_SHUTDOWN;
    end else if (enable_now && (state_reg inside {ST_MAIN_RAMP, ST_MAIN_ON, ST_SERVO}) && mon_reg.hiccup_fault) begin
      state_next = ST_MAIN_ERROR;
    end else begin
      unique case (state_reg)
        ST_NO_POWER:      state_next = ST_BIAS_RAMP;
        ST_BIAS_RAMP:     if (mon_reg.mini_up) state_next = ST_FREQ_CHECK;
        ST_FREQ_CHECK:    if (mon_reg.freq_valid) state_next = ST_BIAS_READY;
        ST_BIAS_READY:    if (enable_now && !enable_prev) state_next = ST_MAIN_RAMP;
        ST_MAIN_RAMP:     if (mon_reg.output_good && !output_good_prev_reg) state_next = ST_MAIN_ON;
        ST_MAIN_ON:       if (target_change) state_next = ST_SERVO;
        ST_SERVO:         if (mon_reg.servo_done) state_next = ST_MAIN_ON;
        ST_BIAS_RESET:    if (delay_done) state_next = ST_BIAS_RAMP;
        ST_MAIN_SHUTDOWN: if (mon_reg.shutdown_done) state_next = ST_BIAS_READY;
        ST_MAIN_ERROR: begin
          if (ien_prev && !ien_now) state_next = ST_BIAS_READY;
          else if (mon_reg.hiccup_timeout) state_next = ST_MAIN_RAMP;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ST_NO_POWER;
    end else begin
      state_reg <= state_next;
    end
  end

  // Indicator outputs, registered from the next state so they track the state exactly
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bias_good   <= 1'b0;
      o_output_good <= 1'b0;
      o_main_enable <= 1'b0;
      o_state       <= ST_NO_POWER;
    end else begin
      o_bias_good   <= state_next inside {ST_BIAS_READY, ST_MAIN_RAMP, ST_MAIN_ON, ST_SERVO};
      o_output_good <= (state_next == ST_MAIN_ON);
      o_main_enable <= state_next inside {ST_MAIN_RAMP, ST_MAIN_ON, ST_SERVO};
      o_state       <= state_next;
    end
  end

  // Strap is caught at the end of bias ramp, once the pin has settled
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_clk_role <= '0;
    end else if (state_reg == ST_BIAS_RAMP) begin
      o_clk_role.sync_enable    <= (strap_reg != 3'h0);
      o_clk_role.sync_is_output <= (strap_reg >= 3'h5);
      o_clk_role.sync_falling   <= (strap_reg inside {3'h2, 3'h4});
    end
  end
  logic [2:0] addr_lo_reg;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      addr_lo_reg <= 3'h0;
    end else if (state_reg == ST_BIAS_RAMP) begin
      addr_lo_reg <= (strap_reg > 3'h5) ? 3'h5 : strap_reg;
    end
  end

  // I2C target
  rcsm_i2c_e  i2c_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg, ptr_reg, tx_reg;
  logic       ack_phase_reg, is_read_reg, host_nack_reg;
  logic       wr_strobe;
  logic [7:0] wr_ofs;
  logic [7:0] status_byte;
  assign status_byte = {o_state, 1'b0, o_main_enable, o_output_good, o_bias_good};
  // Byte at the current pointer, shared by both read load points
  logic [7:0] rd_byte;
  assign rd_byte = read_mux(ptr_reg, status_byte);

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      i2c_reg       <= I2C_IDLE;
      bit_cnt_reg   <= 4'h0;
      shift_reg     <= 8'h00;
      ptr_reg       <= 8'h00;
      tx_reg        <= 8'h00;
      ack_phase_reg <= 1'b0;
      is_read_reg   <= 1'b0;
      host_nack_reg <= 1'b0;
      o_sda_oe_n    <= 1'b1;
    end else if (!o_bias_good) begin
      i2c_reg    <= I2C_IDLE;
      o_sda_oe_n <= 1'b1;
    end else if (stop_seen) begin
      i2c_reg    <= I2C_IDLE;
      o_sda_oe_n <= 1'b1;
    end else if (start_seen) begin
      i2c_reg       <= I2C_ADDR;
      bit_cnt_reg   <= 4'h0;
      ack_phase_reg <= 1'b0;
      o_sda_oe_n    <= 1'b1;
    end else if (scl_rise && i2c_reg != I2C_IDLE && i2c_reg != I2C_IGNORE) begin
      if (ack_phase_reg) begin
        host_nack_reg <= sda_now;
      end else begin
        shift_reg   <= {shift_reg[6:0], sda_now};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        if (i2c_reg == I2C_RDATA && bit_cnt_reg == (`RCSM_PTR_INC_BIT - 4'h1)) begin
          ptr_reg <= ptr_reg + 8'h01;
        end
      end
    end else if (scl_fall && i2c_reg != I2C_IDLE && i2c_reg != I2C_IGNORE) begin
      if (ack_phase_reg) begin
        // End of acknowledge slot
        ack_phase_reg <= 1'b0;
        bit_cnt_reg   <= 4'h0;
        o_sda_oe_n    <= 1'b1;
        if (i2c_reg == I2C_ADDR) begin
          i2c_reg <= is_read_reg ? I2C_RDATA : I2C_REGADDR;
          if (is_read_reg) begin
            tx_reg     <= rd_byte;
            o_sda_oe_n <= rd_byte[7];
          end
        end else if (i2c_reg == I2C_REGADDR) begin
          i2c_reg <= I2C_WDATA;
        end else if (i2c_reg == I2C_RDATA) begin
          if (host_nack_reg) begin
            i2c_reg <= I2C_IGNORE;
          end else begin
            tx_reg     <= rd_byte;
            o_sda_oe_n <= rd_byte[7];
          end
        end
      end else if (bit_cnt_reg == 4'h8) begin
        // Eighth bit done: decide on acknowledge
        if (i2c_reg == I2C_ADDR) begin
          if (shift_reg[7:1] == {`RCSM_I2C_ADDR_HI, addr_lo_reg}) begin
            ack_phase_reg <= 1'b1;
            is_read_reg   <= shift_reg[0];
            o_sda_oe_n    <= 1'b0;
          end else begin
            i2c_reg <= I2C_IGNORE;
          end
        end else if (i2c_reg == I2C_RDATA) begin
          ack_phase_reg <= 1'b1;
          o_sda_oe_n    <= 1'b1;
        end else begin
          ack_phase_reg <= 1'b1;
          o_sda_oe_n    <= 1'b0;
          if (i2c_reg == I2C_REGADDR) begin
            ptr_reg <= shift_reg;
          end else begin
            ptr_reg <= ptr_reg + 8'h01;
          end
        end
      end else if (i2c_reg == I2C_RDATA) begin
        tx_reg     <= {tx_reg[6:0], 1'b0};
        o_sda_oe_n <= tx_reg[6];
      end
    end
  end

  // Write strobe fires as the data byte is acknowledged, using the pointer before its increment
  assign wr_strobe = scl_fall && !ack_phase_reg && bit_cnt_reg == 4'h8 && i2c_reg == I2C_WDATA
                     && o_bias_good && !stop_seen && !start_seen;
  assign wr_ofs    = ptr_reg;
  assign target_change = wr_strobe && (wr_ofs inside {`RCSM_OFS_VOUT_HI, `RCSM_OFS_VOUT_LO, `RCSM_OFS_ILIM});

  // Setting registers; the drive fields store what the host writes, never 01/10 by contract
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      vout_hi_reg  <= `RCSM_VOUT_HI_RST;
      vout_lo_reg  <= `RCSM_VOUT_LO_RST;
      ilim_reg     <= `RCSM_ILIM_RST;
      mini_cfg_reg <= `RCSM_MINI_CFG_RST;
    end else if (wr_strobe) begin
      unique case (wr_ofs)
        `RCSM_OFS_VOUT_HI:  vout_hi_reg  <= shift_reg;
        `RCSM_OFS_VOUT_LO:  vout_lo_reg  <= shift_reg;
        `RCSM_OFS_ILIM:     ilim_reg     <= shift_reg;
        `RCSM_OFS_MINI_CFG: mini_cfg_reg <= {shift_reg[7:1], 1'b0};
        default:            ;
      endcase
    end
  end

  // Configuration fields to the mini converter
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mini_cfg <= 7'(`RCSM_MINI_CFG_RST >> 1); // Bit 0 is unused, so it is dropped
    end else begin
      o_mini_cfg.full_duty                <= mini_cfg_reg[`RCSM_BIT_FULL_DUTY];
      o_mini_cfg.spread                   <= mini_cfg_reg[`RCSM_BIT_SPREAD];
      o_mini_cfg.fccm                     <= mini_cfg_reg[`RCSM_BIT_FCCM];
      o_mini_cfg.high_side_drive_strength <= mini_cfg_reg[`RCSM_HSD_MSB:`RCSM_HSD_LSB];
      o_mini_cfg.low_side_drive_strength  <= mini_cfg_reg[`RCSM_LSD_MSB:`RCSM_LSD_LSB];
    end
  end
endmodule

// ==== rcsm_control_chk.sv ====
// Assertion checker bound to the regulator control block
`timescale 1ns/1ps
`include "rcsm_map.svh"
module rcsm_control_chk #(
  parameter int unsigned BIAS_RESET_CYC = `RCSM_BIAS_RESET_CYC
) (
  input wire logic                  i_core_clk,
  input wire logic                  i_rst_n,
  input wire rcsm_pkg::rcsm_mon_s   i_mon,
  input wire logic                  i_enable,
  input wire logic                  o_sda_oe_n,
  input wire logic                  o_bias_good,
  input wire logic                  o_output_good,
  input wire rcsm_pkg::rcsm_state_e o_state
);
  import rcsm_pkg::*;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  logic [15:0] dwell_reg;
  // Cycles spent in bias reset; a stuck delay counter shows up as an overrun
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) dwell_reg <= 16'h0000;
    else if (o_state == ST_BIAS_RESET) dwell_reg <= dwell_reg + 16'h0001;
    else dwell_reg <= 16'h0000;
  end
  a_power_loss_off: assert property (!i_mon.power_ok [*6] |-> o_state == ST_NO_POWER)
    else $error("state not unpowered after power loss");
  a_ready_to_ramp: assert property (o_state == ST_BIAS_READY && $rose(i_enable) |-> ##[1:8] o_state == ST_MAIN_RAMP)
    else $error("enable rise did not start the ramp");
  a_ramp_to_on: assert property (o_state == ST_MAIN_RAMP && $rose(i_mon.output_good) |-> ##[1:8] o_state == ST_MAIN_ON)
    else $error("output good rise did not reach on");
  a_on_goods: assert property ((o_state == ST_MAIN_ON) [*2] |-> o_bias_good && o_output_good)
    else $error("goods not both high while on");
  a_servo_goods: assert property ((o_state == ST_SERVO) [*2] |-> o_bias_good && !o_output_good)
    else $error("goods wrong during servo");
  a_reset_dwell_max: assert property (dwell_reg <= BIAS_RESET_CYC + 8)
    else $error("bias reset overstayed its delay");
  a_reset_dwell_min: assert property ($past(o_state) == ST_BIAS_RESET && o_state != ST_BIAS_RESET && i_mon.power_ok |-> dwell_reg >= BIAS_RESET_CYC - 1)
    else $error("bias reset left before its delay");
  a_shutdown_entry: assert property ($rose(i_mon.shutdown_fault) && i_enable && o_state == ST_MAIN_ON |-> ##[1:8] o_state == ST_MAIN_SHUTDOWN)
    else $error("latch-off fault did not shut down");
  a_hiccup_entry: assert property ($rose(i_mon.hiccup_fault) && i_enable
                                   && (o_state inside {ST_MAIN_RAMP, ST_MAIN_ON, ST_SERVO})
                                   |-> ##[1:8] o_state == ST_MAIN_ERROR)
    else $error("hiccup fault did not enter error");
  a_quiet_unbiased: assert property (!o_bias_good [*2] |-> o_sda_oe_n)
    else $error("data line pulled without bias good");
  c_servo: cover property (o_state == ST_SERVO);
  c_bias_reset: cover property (o_state == ST_BIAS_RESET);
  c_error: cover property (o_state == ST_MAIN_ERROR);
  c_ack: cover property (!o_sda_oe_n);
endmodule
bind rcsm_control rcsm_control_chk #(.BIAS_RESET_CYC(BIAS_RESET_CYC)) rcsm_control_chk_i (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_mon(i_mon), .i_enable(i_enable), .o_sda_oe_n(o_sda_oe_n),
  .o_bias_good(o_bias_good), .o_output_good(o_output_good), .o_state(o_state));

// ==== rcsm_host_model.sv ====
// I2C host model driving the clock and data lines of the regulator control block
`timescale 1ns/1ps
module rcsm_host_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_sda,
  output logic            o_scl,
  output logic            o_sda_oe_n,
  output logic            o_res_valid,
  output logic [7:0]      o_res
);
  // Idle bus: both lines left to the pull-ups
  initial begin
    o_scl = 1'b1;
    o_sda_oe_n = 1'b1;
    o_res_valid = 1'b0;
    o_res = 8'h00;
  end
  // Wait n clocks, then step just past the edge
  task automatic w(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  // Hand one result to the bench for exactly one clock
  task automatic emit(input logic [7:0] v);
    o_res = v;
    o_res_valid = 1'b1;
    w(1);
    o_res_valid = 1'b0;
  endtask
  // Start or repeated start: data falls while the clock is high
  task automatic start();
    w(6);
    o_sda_oe_n = 1'b1;
    w(6);
    o_scl = 1'b1;
    w(8);
    o_sda_oe_n = 1'b0;
    w(8);
    o_scl = 1'b0;
  endtask
  task automatic stop();
    w(6);
    o_sda_oe_n = 1'b0;
    w(6);
    o_scl = 1'b1;
    w(8);
    o_sda_oe_n = 1'b1;
    w(8);
  endtask
  // Nine bit slots, MSB first; data set 6 clocks into low so a late target release never collides
  task automatic slot(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      w(6);
      o_sda_oe_n = d[i];
      w(6);
      o_scl = 1'b1;
      w(4);
      q[i] = i_sda;
      w(4);
      o_scl = 1'b0;
    end
  endtask
  // Send a byte and report the acknowledge bit seen
  task automatic put(input logic [7:0] b);
    logic [8:0] q;
    slot({b, 1'b1}, q);
    emit({7'h00, q[0]});
  endtask
  // Receive a byte, answering ack (0) or nack (1)
  task automatic get(input logic nack);
    logic [8:0] q;
    slot({8'hff, nack}, q);
    emit(q[8:1]);
  endtask
endmodule

// ==== rcsm_control_tb_top.sv ====
// Self-checking bench for the regulator control block
`timescale 1ns/1ps
`include "rcsm_map.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module rcsm_control_tb_top;
  import rcsm_pkg::*;
  localparam int unsigned RST_CYC = 20;
  logic           i_core_clk;
  logic           i_rst_n = 1'b0;
  rcsm_mon_s      i_mon = '0;
  logic           i_enable = 1'b0;
  logic           internal_enable_gated = 1'b1;
  logic [2:0]     strap = 3'h0;
  logic           scl, host_oe_n, dut_oe_n, bg, og, men, res_valid;
  logic [7:0]     res, ev;
  logic [6:0]     dev;
  rcsm_state_e    st;
  rcsm_mini_cfg_s cfg;
  rcsm_clk_role_s role;
  logic [7:0]     exp_q[$];
  string          nm_q[$], en;
  int             err_total = 0, check_count = 0, cyc = 0, seed = 30;
  // Open-drain data line with pull-up
  wire sda = dut_oe_n & host_oe_n;
  initial begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end
  rcsm_control #(.BIAS_RESET_CYC(RST_CYC)) rcsm_control_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_mon(i_mon), .i_enable(i_enable), .i_internal_enable_gated(internal_enable_gated), .i_address_strap_resistor(strap),
    .i_scl(scl), .i_sda(sda), .o_sda_oe_n(dut_oe_n), .o_bias_good(bg), .o_output_good(og),
    .o_main_enable(men), .o_state(st), .o_mini_cfg(cfg), .o_clk_role(role));
  rcsm_host_model rcsm_host_model_i (.i_core_clk(i_core_clk), .i_sda(sda), .o_scl(scl),
    .o_sda_oe_n(host_oe_n), .o_res_valid(res_valid), .o_res(res));
  // Pair each bus result with the oldest expectation
  always @(posedge i_core_clk) begin
    if (res_valid === 1'b1) begin
      en = (nm_q.size() > 0) ? nm_q.pop_front() : "spare result";
      ev = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
      `CHK(en, ev, res)
    end
  end
  // Cycle ceiling well above the expected run length
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc > 40000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (exp_q.size() != 0) err_total++;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  // Bounded wait for the state machine to reach s
  task automatic go(input rcsm_state_e s);
    for (int i = 0; i < 60 && st !== s; i++) tick(1);
    `CHK("state", s, st)
  endtask
  task automatic ex(input string n, input logic [7:0] v);
    nm_q.push_back(n);
    exp_q.push_back(v);
  endtask
  // Lone address byte; a silent target leaves the ack bit high
  task automatic probe(input logic [7:0] a, input logic [7:0] e);
    rcsm_host_model_i.start();
    ex("addr ack", e);
    rcsm_host_model_i.put(a);
    rcsm_host_model_i.stop();
  endtask
  task automatic wr(input logic [7:0] r, input logic [7:0] d[$]);
    rcsm_host_model_i.start();
    ex("addr ack", 8'h00);
    rcsm_host_model_i.put({dev, 1'b0});
    ex("reg ack", 8'h00);
    rcsm_host_model_i.put(r);
    foreach (d[i]) begin
      ex("data ack", 8'h00);
      rcsm_host_model_i.put(d[i]);
    end
    rcsm_host_model_i.stop();
  endtask
  // Optional pointer write, then a read of e.size() bytes with nack on the last
  task automatic rd(input bit set, input logic [7:0] r, input logic [7:0] e[$]);
    rcsm_host_model_i.start();
    if (set) begin
      ex("addr ack", 8'h00);
      rcsm_host_model_i.put({dev, 1'b0});
      ex("reg ack", 8'h00);
      rcsm_host_model_i.put(r);
      rcsm_host_model_i.start();
    end
    ex("addr ack", 8'h00);
    rcsm_host_model_i.put({dev, 1'b1});
    foreach (e[i]) begin
      ex("read data", e[i]);
      rcsm_host_model_i.get(i == e.size() - 1);
    end
    rcsm_host_model_i.stop();
  endtask
  // Main sequence: strap sweep with config traffic, pointer walk, then the state tour
  initial begin
    logic [7:0] d;
    tick(10);
    i_rst_n = 1'b1;
    `CHK("cfg reset", `RCSM_MINI_CFG_RST >> 1, cfg)
    for (int s = 0; s < 6; s++) begin
      strap = 3'(s);
      dev = {`RCSM_I2C_ADDR_HI, strap};
      probe({dev, 1'b0}, 8'h01);
      i_mon.power_ok = 1'b1;
      go(ST_BIAS_RAMP);
      i_mon.mini_up = 1'b1;
      go(ST_FREQ_CHECK);
      i_mon.freq_valid = 1'b1;
      go(ST_BIAS_READY);
      tick(4);
      `CHK("bias good", 1'b1, bg)
      `CHK("clk role", {strap != 3'h0, strap == 3'h5, strap != 3'h0 && strap != 3'h5 && !strap[0]}, role)
      probe({4'h2, strap, 1'b0}, 8'h01);
      d = 8'($random(seed));
      d[4:3] = {2{d[4]}};
      d[2:1] = {2{d[2]}};
      wr(`RCSM_OFS_MINI_CFG, '{d});
      rd(1'b1, `RCSM_OFS_MINI_CFG, '{d & 8'hfe});
      `CHK("cfg out", d[7:1], cfg)
      if (s < 5) begin
        i_mon = '0;
        go(ST_NO_POWER);
      end
    end
    wr(`RCSM_OFS_VOUT_LO, '{8'h5a, 8'ha5});
    rd(1'b1, `RCSM_OFS_VOUT_LO, '{8'h5a, 8'ha5});
    rd(1'b0, 8'h00, '{8'h00});
    rd(1'b1, `RCSM_OFS_STATUS, '{8'h31});
    i_enable = 1'b1;
    go(ST_MAIN_RAMP);
    `CHK("main enable", 1'h1, men)
    i_mon.output_good = 1'b1;
    go(ST_MAIN_ON);
    `CHK("goods on", 2'h3, {bg, og})
    wr(`RCSM_OFS_ILIM, '{8'h80});
    go(ST_SERVO);
    `CHK("servo goods", 2'h2, {bg, og})
    i_mon.servo_done = 1'b1;
    go(ST_MAIN_ON);
    i_mon.servo_done = 1'b0;
    i_mon.shutdown_fault = 1'b1;
    go(ST_MAIN_SHUTDOWN);
    i_mon.shutdown_fault = 1'b0;
    i_mon.output_good = 1'b0;
    i_mon.shutdown_done = 1'b1;
    go(ST_BIAS_READY);
    i_mon.shutdown_done = 1'b0;
    i_enable = 1'b0;
    tick(8);
    i_enable = 1'b1;
    go(ST_MAIN_RAMP);
    i_mon.hiccup_fault = 1'b1;
    go(ST_MAIN_ERROR);
    i_mon.hiccup_fault = 1'b0;
    i_mon.hiccup_timeout = 1'b1;
    go(ST_MAIN_RAMP);
    i_mon.hiccup_timeout = 1'b0;
    i_mon.output_good = 1'b1;
    go(ST_MAIN_ON);
    internal_enable_gated = 1'b0;
    go(ST_MAIN_SHUTDOWN);
    internal_enable_gated = 1'b1;
    i_mon.shutdown_done = 1'b1;
    go(ST_BIAS_READY);
    i_mon.shutdown_done = 1'b0;
    // Error state left by a falling internal enable instead of the timeout
    i_enable = 1'b0;
    tick(8);
    i_enable = 1'b1;
    go(ST_MAIN_RAMP);
    i_mon.hiccup_fault = 1'b1;
    go(ST_MAIN_ERROR);
    i_mon.hiccup_fault = 1'b0;
    internal_enable_gated = 1'b0;
    go(ST_BIAS_READY);
    internal_enable_gated = 1'b1;
    i_mon.bias_fault = 1'b1;
    go(ST_BIAS_RESET);
    i_mon.bias_fault = 1'b0;
    go(ST_BIAS_RAMP);
    go(ST_BIAS_READY);
    i_mon.power_ok = 1'b0;
    go(ST_NO_POWER);
    end_sim();
  end
endmodule
